//--- shared/orsre_pkg.sv
`default_nettype none
package orsre_pkg;
  // Opcodes and subcodes
  localparam logic [7:0] OP_OR2 = 8'h21;
  localparam logic [7:0] OP_OR3 = 8'h31;
  localparam logic [7:0] OP_ORI = 8'h01;
  localparam logic [7:0] OP_REM2 = 8'h25;
  localparam logic [7:0] OP_THREE_OPERAND_REMAINDER_OP = 8'h35;
  localparam logic [7:0] OP_SHORT = 8'h02;
  localparam logic [7:0] OP_LONG = 8'h00;
  localparam logic [3:0] SUB_POP_S = 4'h3;
  localparam logic [3:0] SUB_POP_L = 4'hF;
  localparam logic [3:0] SUB_RET_S = 4'h2;
  localparam logic [3:0] SUB_RET_L = 4'h2;
  // Offset handling: short offset is scaled by 16, pointer adjust ignores low 4 offset bits
  localparam logic [19:0] SHORT_PAD = 20'h00000;
  localparam logic [3:0] QUAD_ZERO = 4'h0;
  localparam logic [31:0] QUAD_MASK = 32'hFFFFFFF0;
  // Reset values
  localparam logic [31:0] PTR_RST = 32'h00000000;
  localparam logic [31:0] DATA_RST = 32'h00000000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DRAIN, ST_RDLK, ST_WRLK, ST_WRACC, ST_RETRD, ST_STKUPD
  } orsre_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [3:0] subcode;
    logic shortForm;
    logic srcStkOff;
    logic userStackCur;
    logic [31:0] src;
    logic [31:0] dst;
    logic dstInMem;
    logic dstInCache;
    logic dstIsAcc;
    logic [31:0] dstAddr;
    logic accInCache;
    logic [31:0] accAddr;
  } orsre_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic lock;
    logic [31:0] addr;
    logic [31:0] wdata;
  } orsre_bus_t;

  typedef struct packed {
    logic done;
    logic dstWe;
    logic [31:0] dstData;
    logic accWe;
    logic [31:0] accData;
    logic pcWe;
    logic [31:0] pcData;
    logic vClr;
    logic illegal;
    logic zeroDiv;
  } orsre_res_t;

  typedef struct packed {
    logic [31:0] user;
    logic [31:0] intr;
    logic [31:0] shadow;
    logic [31:0] highMark;
  } orsre_stk_t;

  typedef struct packed {
    orsre_state_t fsm;
    orsre_req_t lat;
    orsre_bus_t bus;
    orsre_res_t res;
    orsre_stk_t stk;
    logic intOff;
    logic busy;
    logic [31:0] hold;
    logic [31:0] ofs;
  } orsre_regs_t;
endpackage
`default_nettype wire

//--- rtl/orsre_exec.sv
// Function
// RULE_01: OR writes destination; three-operand form writes accumulator
// RULE_02: Interlocked OR stores OR, accumulator gets old
// RULE_03: Lock from destination read until write completes
// RULE_04: No other bus access inside locked pair
// RULE_05: Accumulator memory write only after interlocked accesses
// RULE_06: Drain pipeline first, admit nothing until done
// RULE_07: Accumulator as destination leaves it unchanged
// RULE_08: Memory guarantees accumulator update never faults
// RULE_09: Pop adds offset to current and shadow
// RULE_10: High mark follows user pointer upward only
// RULE_11: Short offset zero-extended and scaled by 16
// RULE_12: Non stack-offset mode or negative offset illegal
// RULE_13: Remainder two's complement, destination or accumulator
// RULE_14: Zero divisor raises zero-divide, no result
// RULE_15: Remainder clears overflow, keeps carry
// RULE_16: Return loads program counter, adjusts both pointers
// RULE_17: Pointer adjust ignores low four offset bits
// RULE_18: Cached interlocked destination handled without lock
`default_nettype none
module orsre_exec (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  // Instruction request
  input wire logic start,
  input wire orsre_pkg::orsre_req_t req,
  input wire logic pipeEmpty,
  output logic busy,
  output logic intOff,
  // Results
  output orsre_pkg::orsre_res_t res,
  // Stack pointers
  input wire logic stkLoadEn,
  input wire orsre_pkg::orsre_stk_t stkLoadVal,
  output orsre_pkg::orsre_stk_t stk,
  // Memory bus
  output orsre_pkg::orsre_bus_t mem,
  input wire logic memAck,
  input wire logic [31:0] memRdata
);
  orsre_pkg::orsre_regs_t r_r;
  orsre_pkg::orsre_regs_t r_nxt;
  logic isOr;
  logic isRem;
  logic isPop;
  logic isRet;
  logic accept;
  logic [31:0] ofsCalc;
  logic [31:0] remVal;
  logic [31:0] curPtr;
  logic [31:0] newPtr;

  assign accept = ce && start && (r_r.fsm == orsre_pkg::ST_IDLE);
  assign isOr = (req.opcode == orsre_pkg::OP_OR2) || (req.opcode == orsre_pkg::OP_OR3);
  assign isRem = (req.opcode == orsre_pkg::OP_REM2) || (req.opcode == orsre_pkg::OP_THREE_OPERAND_REMAINDER_OP);
  assign isPop = (req.opcode == orsre_pkg::OP_SHORT && req.subcode == orsre_pkg::SUB_POP_S)
    || (req.opcode == orsre_pkg::OP_LONG && req.subcode == orsre_pkg::SUB_POP_L);
  assign isRet = (req.opcode == orsre_pkg::OP_SHORT && req.subcode == orsre_pkg::SUB_RET_S)
    || (req.opcode == orsre_pkg::OP_LONG && req.subcode == orsre_pkg::SUB_RET_L);
  // Short offset scaled by 16, long offset taken whole
  assign ofsCalc = req.shortForm ? {orsre_pkg::SHORT_PAD, req.src[7:0], orsre_pkg::QUAD_ZERO}
    : req.src; // RULE_11
  assign remVal = (req.src == orsre_pkg::DATA_RST) ? orsre_pkg::DATA_RST
    : 32'($signed(req.dst) % $signed(req.src)); // RULE_13
  assign curPtr = r_r.lat.userStackCur ? r_r.stk.user : r_r.stk.intr;
  assign newPtr = curPtr + (r_r.ofs & orsre_pkg::QUAD_MASK); // RULE_17

  always_comb begin
    r_nxt = r_r;
    r_nxt.res.done = 1'b0;
    r_nxt.res.dstWe = 1'b0;
    r_nxt.res.accWe = 1'b0;
    r_nxt.res.pcWe = 1'b0;
    r_nxt.res.vClr = 1'b0;
    r_nxt.res.illegal = 1'b0;
    r_nxt.res.zeroDiv = 1'b0;
    unique case (r_r.fsm)
      orsre_pkg::ST_IDLE: begin
        if (start) begin
          r_nxt.lat = req;
          r_nxt.busy = 1'b1;
          if (isOr) begin
            r_nxt.busy = 1'b0;
            r_nxt.res.done = 1'b1;
            if (req.opcode == orsre_pkg::OP_OR3) begin
              r_nxt.res.accWe = 1'b1; // RULE_01
              r_nxt.res.accData = req.dst | req.src;
            end else begin
              r_nxt.res.dstWe = 1'b1; // RULE_01
              r_nxt.res.dstData = req.dst | req.src;
            end
          end else if (isRem) begin
            r_nxt.busy = 1'b0;
            r_nxt.res.done = 1'b1;
            r_nxt.res.vClr = 1'b1; // RULE_15
            if (req.src == orsre_pkg::DATA_RST) begin
              r_nxt.res.zeroDiv = 1'b1; // RULE_14
            end else if (req.opcode == orsre_pkg::OP_THREE_OPERAND_REMAINDER_OP) begin
              r_nxt.res.accWe = 1'b1; // RULE_13
              r_nxt.res.accData = remVal;
            end else begin
              r_nxt.res.dstWe = 1'b1; // RULE_13
              r_nxt.res.dstData = remVal;
            end
          end else if (isPop || isRet) begin
            if (!req.srcStkOff || (!req.shortForm && req.src[31])) begin
              r_nxt.busy = 1'b0; // RULE_12
              r_nxt.res.done = 1'b1;
              r_nxt.res.illegal = 1'b1;
            end else begin
              r_nxt.intOff = 1'b1; // RULE_09 RULE_16
              r_nxt.ofs = ofsCalc;
              if (isRet) begin
                r_nxt.fsm = orsre_pkg::ST_RETRD;
                r_nxt.bus.valid = 1'b1;
                r_nxt.bus.write = 1'b0;
                r_nxt.bus.lock = 1'b0;
                r_nxt.bus.addr = (req.userStackCur ? r_r.stk.user : r_r.stk.intr) + ofsCalc;
              end else begin
                r_nxt.fsm = orsre_pkg::ST_STKUPD;
              end
            end
          end else if (req.opcode == orsre_pkg::OP_ORI) begin
            r_nxt.fsm = orsre_pkg::ST_DRAIN; // RULE_06
          end else begin
            r_nxt.busy = 1'b0;
            r_nxt.res.done = 1'b1;
            r_nxt.res.illegal = 1'b1;
          end
        end else if (stkLoadEn) begin
          r_nxt.stk = stkLoadVal;
        end
      end
      orsre_pkg::ST_DRAIN: begin
        if (pipeEmpty) begin // RULE_06
          if (r_r.lat.dstInMem && !r_r.lat.dstInCache) begin
            r_nxt.fsm = orsre_pkg::ST_RDLK;
            r_nxt.bus.valid = 1'b1;
            r_nxt.bus.write = 1'b0;
            r_nxt.bus.lock = 1'b1; // RULE_03
            r_nxt.bus.addr = r_r.lat.dstAddr;
          end else begin
            // Internal path, the bus stays unlocked
            r_nxt.fsm = orsre_pkg::ST_IDLE; // RULE_18
            r_nxt.busy = 1'b0;
            r_nxt.res.done = 1'b1;
            r_nxt.res.accWe = 1'b1; // RULE_02
            r_nxt.res.accData = r_r.lat.dst;
            r_nxt.res.dstWe = !r_r.lat.dstIsAcc; // RULE_07
            r_nxt.res.dstData = r_r.lat.dst | r_r.lat.src;
          end
        end
      end
      orsre_pkg::ST_RDLK: begin
        if (memAck) begin
          // Write follows the read at once, lock stays up
          r_nxt.fsm = orsre_pkg::ST_WRLK; // RULE_04
          r_nxt.hold = memRdata;
          r_nxt.bus.write = 1'b1;
          r_nxt.bus.wdata = memRdata | r_r.lat.src; // RULE_02
        end
      end
      orsre_pkg::ST_WRLK: begin
        if (memAck) begin
          r_nxt.bus.lock = 1'b0; // RULE_03
          if (!r_r.lat.accInCache) begin
            r_nxt.fsm = orsre_pkg::ST_WRACC; // RULE_05 RULE_08
            r_nxt.bus.addr = r_r.lat.accAddr;
            r_nxt.bus.wdata = r_r.hold;
          end else begin
            r_nxt.bus.valid = 1'b0;
            r_nxt.fsm = orsre_pkg::ST_IDLE;
            r_nxt.busy = 1'b0;
            r_nxt.res.done = 1'b1;
            r_nxt.res.accWe = 1'b1; // RULE_02
            r_nxt.res.accData = r_r.hold;
          end
        end
      end
      orsre_pkg::ST_WRACC: begin
        if (memAck) begin
          r_nxt.bus.valid = 1'b0;
          r_nxt.fsm = orsre_pkg::ST_IDLE;
          r_nxt.busy = 1'b0;
          r_nxt.res.done = 1'b1;
        end
      end
      orsre_pkg::ST_RETRD: begin
        if (memAck) begin
          r_nxt.bus.valid = 1'b0;
          r_nxt.res.pcWe = 1'b1; // RULE_16
          r_nxt.res.pcData = memRdata;
          r_nxt.fsm = orsre_pkg::ST_STKUPD;
        end
      end
      orsre_pkg::ST_STKUPD: begin
        r_nxt.stk.shadow = newPtr; // RULE_09 RULE_16
        if (r_r.lat.userStackCur) begin
          r_nxt.stk.user = newPtr;
          if (newPtr > r_r.stk.highMark) begin
            r_nxt.stk.highMark = newPtr; // RULE_10
          end
        end else begin
          r_nxt.stk.intr = newPtr;
        end
        r_nxt.intOff = 1'b0;
        r_nxt.busy = 1'b0;
        r_nxt.res.done = 1'b1;
        r_nxt.fsm = orsre_pkg::ST_IDLE;
      end
      default: begin
        r_nxt.fsm = orsre_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_r <= '0;
      r_r.fsm <= orsre_pkg::ST_IDLE;
      r_r.stk.user <= orsre_pkg::PTR_RST;
      r_r.stk.intr <= orsre_pkg::PTR_RST;
      r_r.stk.shadow <= orsre_pkg::PTR_RST;
      r_r.stk.highMark <= orsre_pkg::PTR_RST;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  assign busy = r_r.busy;
  assign intOff = r_r.intOff;
  assign res = r_r.res;
  assign stk = r_r.stk;
  assign mem = r_r.bus;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_lock_read: assert property (mem.valid && !mem.write && r_r.fsm == orsre_pkg::ST_RDLK
    |-> mem.lock) else $error("locked read without lock"); // RULE_03
  a_lock_pair: assert property ($fell(mem.lock) |-> $past(mem.write) && $past(memAck)
    && $past(r_r.fsm) == orsre_pkg::ST_WRLK) else $error("lock dropped early"); // RULE_04
  a_acc_unlocked: assert property (r_r.fsm == orsre_pkg::ST_WRACC |-> mem.valid && mem.write
    && !mem.lock && $past(r_r.fsm) != orsre_pkg::ST_RDLK) else $error("acc write order");
    // RULE_05
  a_drain_wait: assert property (r_r.fsm == orsre_pkg::ST_DRAIN && !pipeEmpty && ce
    |=> r_r.fsm == orsre_pkg::ST_DRAIN && busy) else $error("drain skipped"); // RULE_06
  a_cache_nolock: assert property (r_r.fsm == orsre_pkg::ST_DRAIN && pipeEmpty && ce
    && r_r.lat.dstInCache |=> !mem.lock && !mem.valid && res.done)
    else $error("cached interlock used bus"); // RULE_18
  a_or3_acc: assert property (accept && req.opcode == orsre_pkg::OP_OR3
    |=> res.accWe && !res.dstWe && res.accData == $past(req.dst | req.src))
    else $error("three-operand or result"); // RULE_01
  a_rem_zero: assert property (accept && isRem && req.src == orsre_pkg::DATA_RST
    |=> res.zeroDiv && res.vClr && !res.dstWe && !res.accWe)
    else $error("zero divide not raised"); // RULE_14
  a_pop_illegal: assert property (accept && (isPop || isRet) && !req.srcStkOff
    |=> res.illegal && res.done && !intOff) else $error("illegal mode accepted"); // RULE_12
  a_isp_mark: assert property (r_r.fsm == orsre_pkg::ST_STKUPD && !r_r.lat.userStackCur
    && ce |=> $stable(stk.highMark) && !intOff) else $error("high mark moved on isp");
    // RULE_10
  a_pop_short: assert property (accept && isPop && req.shortForm && req.srcStkOff
    && req.userStackCur && !stkLoadEn ##1 ce [*2]
    |-> stk.user == $past(stk.user, 2) + {20'h00000, $past(req.src[7:0], 2), 4'h0})
    else $error("pop offset wrong"); // RULE_11
  a_or2_dst: assert property (accept && req.opcode == orsre_pkg::OP_OR2 // RULE_01
    |=> res.dstWe && !res.accWe && res.dstData == $past(req.dst | req.src))
    else $error("two-operand or result");
  a_ori_old: assert property (r_r.fsm == orsre_pkg::ST_WRLK && memAck && ce // RULE_02
    && r_r.lat.accInCache |=> res.accWe && res.accData == $past(r_r.hold))
    else $error("old destination not in accumulator");
  a_lock_write: assert property (r_r.fsm == orsre_pkg::ST_WRLK // RULE_03
    |-> mem.lock && mem.valid && mem.write) else $error("locked write without lock");
  a_acc_self: assert property (r_r.fsm == orsre_pkg::ST_DRAIN && pipeEmpty && ce // RULE_07
    && r_r.lat.dstIsAcc && !(r_r.lat.dstInMem && !r_r.lat.dstInCache)
    |=> !res.dstWe && res.accData == $past(r_r.lat.dst)) else $error("accumulator changed");
  a_pop_done: assert property (r_r.fsm == orsre_pkg::ST_STKUPD && ce // RULE_09
    |=> !intOff && !busy && res.done) else $error("pointer update not closed");
  a_mark_user: assert property (r_r.fsm == orsre_pkg::ST_STKUPD && ce // RULE_10
    && r_r.lat.userStackCur && newPtr > r_r.stk.highMark
    |=> stk.highMark == $past(newPtr)) else $error("high mark not raised");
  a_rem_vclr: assert property (accept && isRem // RULE_15
    |=> res.vClr && res.done) else $error("overflow not cleared");
  a_ret_read: assert property (accept && isRet && req.srcStkOff // RULE_16
    && (req.shortForm || !req.src[31])
    |=> mem.valid && !mem.write && !mem.lock && intOff) else $error("return read missing");
  a_ret_pc: assert property (r_r.fsm == orsre_pkg::ST_RETRD && memAck && ce // RULE_16
    |=> res.pcWe && res.pcData == $past(memRdata)) else $error("return pc not loaded");
endmodule
`default_nettype wire

//--- tb/orsre_mem_model.sv
`default_nettype none
module orsre_mem_model #(
  parameter logic [31:0] KEY = 32'h00000000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Answer delay in cycles
  input wire logic [3:0] lat,
  // Processor bus
  input wire orsre_pkg::orsre_bus_t mem,
  output logic memAck,
  output logic [31:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      memAck <= 1'h0;
      memRdata <= 32'h00000000;
    end else if (mem.valid && !memAck && cnt >= lat) begin
      // Every access is answered, none faults
      cnt <= 4'h0;
      memAck <= 1'h1;
      memRdata <= mem.addr ^ KEY;
    end else begin
      cnt <= (mem.valid && !memAck) ? cnt + 4'h1 : 4'h0;
      memAck <= 1'h0;
      // Released data bus toggles so a stale value matches again only every second cycle
      memRdata <= ~memRdata;
    end
  end
endmodule
`default_nettype wire

//--- tb/or_rem_stack_return_exec_test.sv
`default_nettype none
module or_rem_stack_return_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] KEY = 32'h5A5A0000;
  logic mclk, arst_n, ce, start, pipeEmpty, busy, intOff, stkLoadEn, memAck, ioff;
  logic [31:0] memRdata;
  logic [3:0] lat;
  orsre_pkg::orsre_req_t req, r;
  orsre_pkg::orsre_res_t res, got;
  orsre_pkg::orsre_stk_t stkLoadVal, stk;
  orsre_pkg::orsre_bus_t mem;
  orsre_pkg::orsre_bus_t acc[$];
  int num_errors, checked;
  orsre_exec orsre_exec_inst (.mclk(mclk), .arst_n(arst_n), .ce(ce), .start(start),
    .req(req), .pipeEmpty(pipeEmpty), .busy(busy), .intOff(intOff), .res(res),
    .stkLoadEn(stkLoadEn), .stkLoadVal(stkLoadVal), .stk(stk), .mem(mem),
    .memAck(memAck), .memRdata(memRdata));
  orsre_mem_model #(.KEY(KEY)) orsre_mem_model_inst (.mclk(mclk), .arst_n(arst_n),
    .lat(lat), .mem(mem), .memAck(memAck), .memRdata(memRdata));
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (mem.valid && memAck) acc.push_back(mem);
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t %s: got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic run();
    int n;
    acc.delete();
    @(negedge mclk);
    req = r;
    start = 1'h1;
    @(negedge mclk);
    start = 1'h0;
    ioff = intOff;
    for (n = 0; n < 60 && res.done !== 1'h1; n++) @(negedge mclk);
    got = res;
    chk(32'(got.done), 32'h1, "done");
  endtask
  task automatic ld(input orsre_pkg::orsre_stk_t v);
    @(negedge mclk);
    stkLoadVal = v;
    stkLoadEn = 1'h1;
    @(negedge mclk);
    stkLoadEn = 1'h0;
  endtask
  task automatic t_alu();
    for (int i = 0; i < 4; i++) begin
      r = '0;
      r.opcode = i[1] ? (i[0] ? orsre_pkg::OP_THREE_OPERAND_REMAINDER_OP : orsre_pkg::OP_REM2)
        : (i[0] ? orsre_pkg::OP_OR3 : orsre_pkg::OP_OR2);
      r.src = 32'h00000003;
      r.dst = 32'hFFFFFFF9;
      run();
      chk(32'(got.dstWe), 32'(!i[0]), "dst we");
      chk(i[0] ? got.accData : got.dstData, i[1] ? 32'hFFFFFFFF : 32'hFFFFFFFB, "res");
      chk(32'(got.vClr), 32'(i[1]), "v clear");
    end
    r.opcode = orsre_pkg::OP_REM2;
    r.src = 32'h00000000;
    run();
    chk(32'({got.zeroDiv, got.dstWe, got.vClr}), 32'h5, "zero div");
    $display("alu test done");
  endtask
  task automatic t_ori_mem();
    logic [31:0] rd;
    rd = 32'h00000100 ^ KEY;
    r = '0;
    r.opcode = orsre_pkg::OP_ORI;
    r.src = 32'h0000000F;
    r.dstInMem = 1'h1;
    r.dstAddr = 32'h00000100;
    r.accAddr = 32'h00000200;
    lat = 4'h3;
    pipeEmpty = 1'h0;
    fork
      run();
      begin
        repeat (6) @(negedge mclk);
        chk(32'(mem.valid), 32'h0, "early access");
        chk(32'(busy), 32'h1, "busy in drain");
        pipeEmpty = 1'h1;
      end
    join
    chk(32'(acc.size()), 32'h3, "count");
    chk(32'({acc[0].write, acc[0].lock, acc[1].write, acc[1].lock, acc[2].write,
      acc[2].lock}), 32'h1E, "lock");
    chk(acc[1].addr, 32'h00000100, "dst addr");
    chk(acc[1].wdata, rd | 32'h0000000F, "dst data");
    chk(acc[2].addr, 32'h00000200, "acc addr");
    chk(acc[2].wdata, rd, "acc data");
    chk(32'(mem.lock), 32'h0, "unlock");
    $display("interlock memory test done");
  endtask
  task automatic t_ori_int();
    for (int i = 0; i < 2; i++) begin
      r = '0;
      r.opcode = orsre_pkg::OP_ORI;
      r.dstInCache = 1'h1;
      r.dstIsAcc = i[0];
      r.accInCache = 1'h1;
      r.dst = 32'h00001234;
      r.src = 32'h000000FF;
      run();
      chk(32'(acc.size()), 32'h0, "bus used");
      chk(32'({got.accWe, got.dstWe}), {30'h0, 1'h1, !i[0]}, "we");
      chk(got.accData, 32'h00001234, "acc");
      if (!i[0]) chk(got.dstData, 32'h000012FF, "dst");
    end
    $display("interlock cached test done");
  endtask
  task automatic t_pop();
    ld({32'h00001000, 32'h00008000, 32'h00001000, 32'h00001008});
    r = '0;
    r.opcode = orsre_pkg::OP_SHORT;
    r.subcode = orsre_pkg::SUB_POP_S;
    r.shortForm = 1'h1;
    r.srcStkOff = 1'h1;
    r.userStackCur = 1'h1;
    r.src = 32'h000000FF;
    run();
    chk(32'({ioff, intOff}), 32'h2, "int off");
    chk(stk.user, 32'h00001FF0, "user");
    chk(stk.shadow, 32'h00001FF0, "shadow");
    chk(stk.highMark, 32'h00001FF0, "mark");
    r.opcode = orsre_pkg::OP_LONG;
    r.subcode = orsre_pkg::SUB_POP_L;
    r.shortForm = 1'h0;
    r.userStackCur = 1'h0;
    r.src = 32'h00000020;
    run();
    chk(stk.intr, 32'h00008020, "intr");
    chk(stk.shadow, 32'h00008020, "shadow");
    chk(stk.highMark, 32'h00001FF0, "mark");
    $display("pop test done");
  endtask
  task automatic t_ret();
    logic [31:0] ea;
    ld({32'h00001000, 32'h00008000, 32'h00001000, 32'h00009000});
    for (int i = 0; i < 2; i++) begin
      r = '0;
      r.opcode = i[0] ? orsre_pkg::OP_SHORT : orsre_pkg::OP_LONG;
      r.subcode = i[0] ? orsre_pkg::SUB_RET_S : orsre_pkg::SUB_RET_L;
      r.shortForm = i[0];
      r.srcStkOff = 1'h1;
      r.userStackCur = 1'h1;
      r.src = i[0] ? 32'h00000001 : 32'h00000014;
      ea = i[0] ? 32'h00001020 : 32'h00001014;
      lat = i[0] ? 4'h0 : 4'h5;
      run();
      chk(acc[0].addr, ea, "ret addr");
      chk(got.pcData, ea ^ KEY, "pc");
      chk(stk.user, ea & 32'hFFFFFFF0, "user");
      chk(stk.shadow, ea & 32'hFFFFFFF0, "shadow");
      chk(stk.highMark, 32'h00009000, "mark");
    end
    $display("return test done");
  endtask
  task automatic t_bad();
    for (int i = 0; i < 2; i++) begin
      r = '0;
      r.opcode = i[0] ? orsre_pkg::OP_LONG : orsre_pkg::OP_SHORT;
      r.subcode = i[0] ? orsre_pkg::SUB_RET_L : orsre_pkg::SUB_POP_S;
      r.shortForm = !i[0];
      r.srcStkOff = i[0];
      r.userStackCur = 1'h1;
      r.src = 32'h80000010;
      run();
      chk(32'(got.illegal), 32'h1, "illegal");
      chk(stk.user, 32'h00001020, "user kept");
    end
    $display("illegal test done");
  endtask
  task automatic finish_test();
    $display("Errors %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
  initial begin
    arst_n = 1'h0;
    ce = 1'h1;
    start = 1'h0;
    pipeEmpty = 1'h1;
    stkLoadEn = 1'h0;
    stkLoadVal = '0;
    lat = 4'h1;
    r = '0;
    req = '0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'h1;
    t_alu();
    t_ori_mem();
    t_ori_int();
    t_pop();
    t_ret();
    t_bad();
    finish_test();
  end
endmodule
`default_nettype wire
